// [rtl/etsc_pkg.sv]
// Purpose : Shared constants and types for the external trigger switch
// Assumes : AXI4-Lite register access, 32-bit data, 40 MHz aclk
// Notes   : All offsets and field positions live here
package etsc_pkg;

    // ------------------------------------------------------------------
    // Trigger modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ETSC_MODE_OFF     = 2'h0,
        ETSC_MODE_NEGEDGE = 2'h1,
        ETSC_MODE_FAULT   = 2'h2,
        ETSC_MODE_INHIBIT = 2'h3
    } etsc_mode_type;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ETSC_ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ETSC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] ETSC_ADDR_MEMCMD = 8'h08;
    localparam logic [7:0] ETSC_ADDR_MEMSTS = 8'h0C;

    // CONFIG fields
    localparam int ETSC_CFG_PMODE_LSB = 0;
    localparam int ETSC_CFG_SMODE_LSB = 2;
    localparam int ETSC_CFG_AUTO_BIT  = 4;
    localparam int ETSC_CFG_MAN_BIT   = 5;
    localparam int ETSC_CFG_WIDTH     = 6;
    localparam logic [5:0] ETSC_CFG_RESET = 6'h10;

    // STATUS fields
    localparam int ETSC_ST_PLVL_BIT = 0;
    localparam int ETSC_ST_SLVL_BIT = 1;
    localparam int ETSC_ST_SEL_BIT  = 2;
    localparam int ETSC_ST_FLT_BIT  = 3;

    // MEMCMD fields: slot in [2:0], save in [4], recall in [5]
    localparam int ETSC_MC_SLOT_LSB = 0;
    localparam int ETSC_MC_SAVE_BIT = 4;
    localparam int ETSC_MC_RCL_BIT  = 5;

    // MEMSTS fields: valid bits [4:0], recall ok [8], recall fail [9]
    localparam int ETSC_MS_OK_BIT   = 8;
    localparam int ETSC_MS_FAIL_BIT = 9;

    // Setup store
    localparam int ETSC_SLOTS = 5;

    // AXI responses
    localparam logic [1:0] ETSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ETSC_RESP_SLVERR = 2'h2;

endpackage

// [rtl/etsc_store_if.sv]
// Purpose : Carries save and recall requests to the setup store
// Assumes : One request at most per cycle
// Notes   : Store answers a recall in the same cycle as the request
interface etsc_store_if;
    import etsc_pkg::*;
    logic       save;
    logic       recall;
    logic [2:0] slot;
    logic [5:0] cfg_in;
    logic [5:0] cfg_out;
    logic       hit;
    logic [4:0] valid;
    modport ctrl  (output save, output recall, output slot, output cfg_in,
                   input cfg_out, input hit, input valid);
    modport store (input save, input recall, input slot, input cfg_in,
                   output cfg_out, output hit, output valid);
endinterface

// [rtl/etsc_setup_store.sv]
// Purpose : Five-slot configuration store with per-slot valid flags
// Assumes : Slot numbers 0 to 4; others are ignored
// Notes   : Contents hold across reset of the valid flags only
module etsc_setup_store
    import etsc_pkg::*;
(
    input  wire logic  aclk,
    input  wire logic  aresetn,
    etsc_store_if.store st
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [5:0] mem_reg  [ETSC_SLOTS];
    logic [5:0] mem_next [ETSC_SLOTS];
    logic [4:0] valid_reg;
    logic [4:0] valid_next;
    logic       in_range;

    assign in_range   = (st.slot < 3'(ETSC_SLOTS));
    assign st.valid   = valid_reg;
    assign st.cfg_out = in_range ? mem_reg[st.slot] : '0;
    // Hit only answers a recall, so a stale slot number cannot load
    assign st.hit     = st.recall && in_range && valid_reg[st.slot];

    // Per-slot write and valid flag
    genvar g;
    generate
        for (g = 0; g < ETSC_SLOTS; g++) begin : g_slot
            always_comb begin
                mem_next[g] = mem_reg[g];
                if (st.save && st.slot == 3'(g)) begin
                    mem_next[g] = st.cfg_in;
                end
            end
            always_ff @(posedge aclk) begin
                mem_reg[g] <= mem_next[g];
            end
        end
    endgenerate

    // Valid flags mark occupied slots
    always_comb begin
        valid_next = valid_reg;
        if (st.save && in_range) begin
            valid_next[st.slot] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            valid_reg <= '0;
        end else begin
            valid_reg <= valid_next;
        end
    end

endmodule

// [rtl/etsc_top.sv]
// Purpose : External trigger control of a primary/secondary switch
// Assumes : Trigger inputs asynchronous; aclk 40 MHz; AXI4-Lite slave
// Notes   : signal_good inputs come from the stream evaluation logic

module etsc_top
    import etsc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        primary_trigger_input,
    input  wire logic        secondary_trigger_input,
    input  wire logic        primary_signal_good,
    input  wire logic        secondary_signal_good,
    output logic             select_secondary,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------------
    // Trigger synchronisers and edge detect
    // ------------------------------------------------------------------
    logic [1:0] trig_raw;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] last_reg;
    logic [1:0] fall;

    assign trig_raw = {secondary_trigger_input, primary_trigger_input};

    // Two stages; only sync2 is evaluated, sync1 feeds nothing else
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 2'b11;
            sync2_reg <= 2'b11;
            last_reg  <= 2'b11;
        end else begin
            sync1_reg <= trig_raw;
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    assign fall = last_reg & ~sync2_reg;

    // ------------------------------------------------------------------
    // Active configuration
    // ------------------------------------------------------------------
    logic [5:0]    cfg_reg;
    logic [5:0]    cfg_next;
    etsc_mode_type mode [2];
    logic          auto_en;
    logic          manual_sec;

    assign mode[0]    = etsc_mode_type'(cfg_reg[ETSC_CFG_PMODE_LSB +: 2]);
    assign mode[1]    = etsc_mode_type'(cfg_reg[ETSC_CFG_SMODE_LSB +: 2]);
    assign auto_en    = cfg_reg[ETSC_CFG_AUTO_BIT];
    assign manual_sec = cfg_reg[ETSC_CFG_MAN_BIT];

    // ------------------------------------------------------------------
    // Per-trigger mode decode
    // ------------------------------------------------------------------
    logic [1:0] t_edge;
    logic [1:0] t_fault;
    logic [1:0] t_inhibit;

    // Off mode leaves all three terms low, so the input is ignored
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_trig
            always_comb begin
                t_edge[g]    = 1'b0;
                t_fault[g]   = 1'b0;
                t_inhibit[g] = 1'b0;
                unique case (mode[g])
                    ETSC_MODE_OFF: begin
                    end
                    ETSC_MODE_NEGEDGE: begin
                        t_edge[g] = fall[g];
                    end
                    ETSC_MODE_FAULT: begin
                        t_fault[g] = ~sync2_reg[g];
                    end
                    ETSC_MODE_INHIBIT: begin
                        t_inhibit[g] = ~sync2_reg[g];
                    end
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Switch decision
    // ------------------------------------------------------------------
    logic sel_reg;
    logic sel_next;
    logic fault_now;
    logic inhibit_now;

    // Signal loss or a low fault trigger both count as a fault
    assign fault_now   = ~primary_signal_good | (|t_fault);
    assign inhibit_now = |t_inhibit;

    // Edge toggles the path; fault moves to secondary if it is good.
    // Inhibit freezes the path, so it outranks both.
    always_comb begin
        sel_next = sel_reg;
        if (inhibit_now) begin
            sel_next = sel_reg;
        end else if (|t_edge) begin
            sel_next = ~sel_reg;
        end else if (fault_now && secondary_signal_good) begin
            sel_next = 1'b1;
        end else if (!fault_now && auto_en) begin
            sel_next = manual_sec;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
        end
    end

    assign select_secondary = sel_reg;

    // ------------------------------------------------------------------
    // Setup store
    // ------------------------------------------------------------------
    etsc_store_if st ();

    etsc_setup_store u_store (
        .aclk    (aclk),
        .aresetn (aresetn),
        .st      (st)
    );

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    logic        aw_have_reg;
    logic        aw_have_next;
    logic [7:0]  aw_addr_reg;
    logic [7:0]  aw_addr_next;
    logic        w_have_reg;
    logic        w_have_next;
    logic [31:0] w_data_reg;
    logic [31:0] w_data_next;
    logic        w_strb_reg;
    logic        w_strb_next;
    logic        bvalid_reg;
    logic        bvalid_next;
    logic [1:0]  bresp_reg;
    logic [1:0]  bresp_next;
    logic        wr_do;
    logic        mc_save_reg;
    logic        mc_save_next;
    logic        mc_rcl_reg;
    logic        mc_rcl_next;
    logic [2:0]  mc_slot_reg;
    logic [2:0]  mc_slot_next;
    logic        rcl_ok_reg;
    logic        rcl_ok_next;
    logic        rcl_fail_reg;
    logic        rcl_fail_next;

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready  = !w_have_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign wr_do         = aw_have_reg && w_have_reg;

    // Address and data may arrive in either order; commit when both held
    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next  = w_have_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        cfg_next     = cfg_reg;
        mc_save_next = 1'b0;
        mc_rcl_next  = 1'b0;
        mc_slot_next = mc_slot_reg;
        rcl_ok_next  = rcl_ok_reg;
        rcl_fail_next = rcl_fail_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb[0]; // Strobe belongs to the data beat
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // Recall answers one cycle after its command
        if (mc_rcl_reg) begin
            rcl_ok_next  = st.hit;
            rcl_fail_next = !st.hit;
            if (st.hit) begin
                cfg_next = st.cfg_out;
            end
        end
        if (wr_do) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = ETSC_RESP_OKAY;
            unique case (aw_addr_reg)
                ETSC_ADDR_CONFIG: begin
                    if (w_strb_reg) begin
                        cfg_next = w_data_reg[ETSC_CFG_WIDTH-1:0];
                    end
                end
                ETSC_ADDR_MEMCMD: begin
                    if (w_strb_reg) begin
                        mc_slot_next = w_data_reg[ETSC_MC_SLOT_LSB +: 3];
                        mc_save_next = w_data_reg[ETSC_MC_SAVE_BIT];
                        mc_rcl_next  = w_data_reg[ETSC_MC_RCL_BIT]
                                       && !w_data_reg[ETSC_MC_SAVE_BIT];
                    end
                end
                ETSC_ADDR_STATUS, ETSC_ADDR_MEMSTS: begin
                end
                default: begin
                    bresp_next = ETSC_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg  <= 1'b0;
            aw_addr_reg  <= '0;
            w_have_reg   <= 1'b0;
            w_data_reg   <= '0;
            w_strb_reg   <= 1'b0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= ETSC_RESP_OKAY;
            cfg_reg      <= ETSC_CFG_RESET;
            mc_save_reg  <= 1'b0;
            mc_rcl_reg   <= 1'b0;
            mc_slot_reg  <= '0;
            rcl_ok_reg   <= 1'b0;
            rcl_fail_reg <= 1'b0;
        end else begin
            aw_have_reg  <= aw_have_next;
            aw_addr_reg  <= aw_addr_next;
            w_have_reg   <= w_have_next;
            w_data_reg   <= w_data_next;
            w_strb_reg   <= w_strb_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            cfg_reg      <= cfg_next;
            mc_save_reg  <= mc_save_next;
            mc_rcl_reg   <= mc_rcl_next;
            mc_slot_reg  <= mc_slot_next;
            rcl_ok_reg   <= rcl_ok_next;
            rcl_fail_reg <= rcl_fail_next;
        end
    end

    // Save copies the whole active setup into the chosen slot
    assign st.save   = mc_save_reg;
    assign st.recall = mc_rcl_reg;
    assign st.slot   = mc_slot_reg;
    assign st.cfg_in = cfg_reg;

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_reg;
    logic [1:0]  rresp_next;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Status reads show live trigger levels and the switch position
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next  = '0;
            rresp_next  = ETSC_RESP_OKAY;
            unique case (s_axi_araddr)
                ETSC_ADDR_CONFIG: begin
                    rdata_next[ETSC_CFG_WIDTH-1:0] = cfg_reg;
                end
                ETSC_ADDR_STATUS: begin
                    rdata_next[ETSC_ST_PLVL_BIT] = sync2_reg[0];
                    rdata_next[ETSC_ST_SLVL_BIT] = sync2_reg[1];
                    rdata_next[ETSC_ST_SEL_BIT]  = sel_reg;
                    rdata_next[ETSC_ST_FLT_BIT]  = fault_now;
                end
                ETSC_ADDR_MEMCMD: begin
                    rdata_next[ETSC_MC_SLOT_LSB +: 3] = mc_slot_reg;
                end
                ETSC_ADDR_MEMSTS: begin
                    rdata_next[ETSC_SLOTS-1:0]   = st.valid;
                    rdata_next[ETSC_MS_OK_BIT]   = rcl_ok_reg;
                    rdata_next[ETSC_MS_FAIL_BIT] = rcl_fail_reg;
                end
                default: begin
                    rresp_next = ETSC_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= ETSC_RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_inhibit_holds_sel: assert property (
        inhibit_now |=> sel_reg == $past(sel_reg))
        else $error("Switch moved while inhibited");

    a_edge_toggles_sel: assert property (
        (!inhibit_now && mode[0] == ETSC_MODE_NEGEDGE && fall[0])
        |=> sel_reg != $past(sel_reg))
        else $error("Falling edge did not switch");

    a_fault_to_sec: assert property (
        (!inhibit_now && !(|t_edge) && fault_now && secondary_signal_good)
        |=> sel_reg)
        else $error("Fault did not select secondary");

    a_off_ignored: assert property (
        mode[0] == ETSC_MODE_OFF |-> !t_edge[0] && !t_fault[0]
                                     && !t_inhibit[0])
        else $error("Disabled trigger has effect");

    a_sync_latency: assert property (
        ##2 sync2_reg[0] == $past(primary_trigger_input, 2))
        else $error("Trigger sync latency wrong");

    a_recall_empty: assert property (
        (mc_rcl_reg && !st.hit && !wr_do) |=> cfg_reg == $past(cfg_reg))
        else $error("Empty recall changed setup");

    a_recall_loads: assert property (
        (mc_rcl_reg && st.hit && !wr_do)
        |=> cfg_reg == $past(st.cfg_out) && rcl_ok_reg)
        else $error("Recall did not load slot");

    a_save_marks: assert property (
        (mc_save_reg && mc_slot_reg < 3'(ETSC_SLOTS))
        |=> st.valid[$past(mc_slot_reg)])
        else $error("Save did not mark slot");

    a_bresp_after_write: assert property (
        wr_do |=> bvalid_reg)
        else $error("Write not answered");

    c_edge_switch: cover property (fall[0] && mode[0] == ETSC_MODE_NEGEDGE);
    c_fault_switch: cover property (t_fault[1] && !sel_reg ##1 sel_reg);
    c_recall_hit: cover property (mc_rcl_reg && st.hit);
    c_recall_miss: cover property (mc_rcl_reg && !st.hit);

endmodule

// [test/etsc_trig_model.sv]
// Purpose : External equipment driving the two trigger inputs
// Assumes : Its lines move on their own time, not on aclk
// Notes   : The 9 ns lag keeps every change off the clock grid
module etsc_trig_model (
    input  wire logic pri_level,
    input  wire logic sec_level,
    output wire logic primary_trigger_input,
    output wire logic secondary_trigger_input
);
    timeunit 1ns;
    timeprecision 100ps;

    // Foreign source: the lag exercises the input synchronisers
    assign #9 primary_trigger_input   = pri_level;
    assign #9 secondary_trigger_input = sec_level;
endmodule

// [test/tb.sv]
// Purpose : Self-checking bench for the external trigger switch
// Assumes : AXI4-Lite master in the bench, 40 MHz aclk
// Notes   : Drivers queue expected answers; a monitor compares them
module tb
    import etsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        aclk, aresetn, pri_cmd, sec_cmd, psg, ssg, sel;
    wire logic   pti, sti;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0]  wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          failures, total_checks;

    etsc_trig_model trig (.pri_level(pri_cmd), .sec_level(sec_cmd),
        .primary_trigger_input(pti), .secondary_trigger_input(sti));
    etsc_top uut (.aclk(aclk), .aresetn(aresetn),
        .primary_trigger_input(pti), .secondary_trigger_input(sti),
        .primary_signal_good(psg), .secondary_signal_good(ssg),
        .select_secondary(sel), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic finish_test();
        failures += rq.size() + bq.size();
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_read(input logic [33:0] got, input logic [33:0] e);
        total_checks++;
        if (got !== e) begin
            failures++;
            $display("ERROR %0t read got %h exp %h", $time, got, e);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] e);
        total_checks++;
        if (got !== e) begin
            failures++;
            $display("ERROR %0t bresp got %h exp %h", $time, got, e);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        bit aw_ok, w_ok;
        bq.push_back(er);
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                w_ok = 1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er,
                      input logic [31:0] ed);
        rq.push_back({er, ed});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    // Next step of the bench's random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Config write with random junk in the unused upper bits
    task automatic wcfg(input logic [5:0] c);
        seed = lfsr_next(seed);
        wr(ETSC_ADDR_CONFIG, {seed[31:6], c}, ETSC_RESP_OKAY);
    endtask

    // Trigger levels and primary health, then let the syncs settle
    task automatic drive(input logic p, input logic s, input logic g);
        pri_cmd <= p;
        sec_cmd <= s;
        psg <= g;
        repeat (8) @(posedge aclk);
    endtask

    // -------------------------------------------------------------------
    // Clock, monitor and watchdog
    // -------------------------------------------------------------------
    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    // Answers are checked at the handshake edge, oldest note first
    always @(posedge aclk) begin
        if (rvalid && rready) check_read({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) check_resp(bresp, bq.pop_front());
    end

    // A hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        finish_test();
    end

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {pri_cmd, sec_cmd, psg, ssg} = 4'hf;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        seed = 32'h0000_79d1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(ETSC_ADDR_CONFIG, ETSC_RESP_OKAY, 32'h0000_0010);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_0003);
        rd(ETSC_ADDR_MEMSTS, ETSC_RESP_OKAY, 32'h0000_0000);
        rd(8'h10, ETSC_RESP_SLVERR, 32'h0000_0000);
        wr(8'h10, 32'h0000_0005, ETSC_RESP_SLVERR);
        wr(ETSC_ADDR_STATUS, 32'h0000_000f, ETSC_RESP_OKAY);
        rd(ETSC_ADDR_CONFIG, ETSC_RESP_OKAY, 32'h0000_0010);
        drive(1'h0, 1'h0, 1'h1);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_0000);
        drive(1'h1, 1'h1, 1'h1);
        wcfg(6'h05);
        drive(1'h0, 1'h1, 1'h1);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_0006);
        drive(1'h1, 1'h0, 1'h1);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_0001);
        drive(1'h1, 1'h1, 1'h1);
        wcfg(6'h1a);
        drive(1'h0, 1'h1, 1'h1);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_000e);
        drive(1'h1, 1'h1, 1'h1);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_0003);
        drive(1'h1, 1'h1, 1'h0);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_000f);
        // Secondary fault trigger alone also moves the path
        drive(1'h1, 1'h1, 1'h1);
        drive(1'h1, 1'h0, 1'h1);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_000d);
        // Secondary inhibit holds primary through a loss of signal
        drive(1'h1, 1'h1, 1'h1);
        wcfg(6'h1c);
        drive(1'h1, 1'h0, 1'h1);
        drive(1'h1, 1'h0, 1'h0);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_0009);
        // Fault with a bad secondary must not move until it is good
        ssg <= 1'h0;
        drive(1'h1, 1'h1, 1'h0);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_000b);
        ssg <= 1'h1;
        drive(1'h1, 1'h1, 1'h0);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_000f);
        // Trigger low first, so inhibit stands before the signal loss
        drive(1'h1, 1'h1, 1'h1);
        wcfg(6'h13);
        drive(1'h0, 1'h1, 1'h1);
        drive(1'h0, 1'h1, 1'h0);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_000a);
        drive(1'h1, 1'h1, 1'h0);
        rd(ETSC_ADDR_STATUS, ETSC_RESP_OKAY, 32'h0000_000f);
        drive(1'h1, 1'h1, 1'h1);
        // Recall of a slot never saved must fail and change nothing
        wr(ETSC_ADDR_MEMCMD, 32'h0000_0022, ETSC_RESP_OKAY);
        rd(ETSC_ADDR_MEMSTS, ETSC_RESP_OKAY, 32'h0000_0200);
        rd(ETSC_ADDR_CONFIG, ETSC_RESP_OKAY, 32'h0000_0013);
        for (int i = 0; i < 5; i++) begin
            wcfg(6'h20 | 6'(i));
            wr(ETSC_ADDR_MEMCMD, 32'h0000_0010 | 32'(i), ETSC_RESP_OKAY);
            rd(ETSC_ADDR_MEMSTS, ETSC_RESP_OKAY,
               32'h0000_0200 | ((32'h0000_0002 << i) - 1));
        end
        wcfg(6'h00);
        wr(ETSC_ADDR_MEMCMD, 32'h0000_0023, ETSC_RESP_OKAY);
        rd(ETSC_ADDR_CONFIG, ETSC_RESP_OKAY, 32'h0000_0023);
        rd(ETSC_ADDR_MEMSTS, ETSC_RESP_OKAY, 32'h0000_011f);
        rd(ETSC_ADDR_MEMCMD, ETSC_RESP_OKAY, 32'h0000_0003);
        repeat (4) @(posedge aclk);
        finish_test();
    end
endmodule
